// >>> design/external_pin_interrupt_unit.sv
// external pin and pin-change interrupt unit with an apb register slave
//
// Overview of operation
// - pins are sampled whatever their direction, so driving them raises requests
// - pin-change inputs form banks 0-7, 8-15, 16-23, 24-26
// - bank request needs bank enable and global enable; one vector per bank
// - pin-change detection runs without the gated i/o clock
// - per pin sense: 00 low, 01 any change, 10 falling, 11 rising
// - enabled low-level pin requests continuously while held low
// - edge and change sensing on dedicated pins needs the i/o clock
// - low-level detection on dedicated pins runs without the i/o clock
// - level must last through wake-up, else no request is raised
// - pin request needs its enable bit and the global enable
// - pins sampled before edge detection; pulses over one clock detected
// - edge or change sets pin flag; cleared on vector entry or write one
// - pin flag held cleared while pin is in level mode
// - bank flag set by bank change; cleared on entry or write one
// - input counts only when its mask bit and bank enable are set
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
module external_pin_interrupt_unit
    import ext_irq_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [3:0]                ext_irq_pin,
    input  wire logic [26:0]               pin_change_input,
    input  wire logic                      global_irq_enable,
    input  wire logic                      io_clock_run,
    input  wire logic                      irq_ack,
    input  wire logic [2:0]                irq_ack_id,
    output logic      [3:0]                ext_irq_req,
    output logic      [3:0]                pin_change_bank_request,
    output logic                           irq
);
    import ext_irq_pkg::*;

    unit_state_s                 st_ff;
    unit_state_s                 nxt_st;
    logic                        wr_en;
    logic                        setup_ph;
    logic [7:0]                  wr_byte;
    logic [3:0]                  level_mode;
    logic [3:0]                  nxt_level_mode;
    logic [3:0]                  level_low;
    logic [3:0]                  ext_hit;
    logic [26:0]                 pc_chg;
    logic [3:0]                  bank_hit;
    logic [3:0]                  ext_ack_clr;
    logic [3:0]                  bank_ack_clr;
    logic [3:0]                  ext_w1c;
    logic [3:0]                  bank_w1c;

    ////////////////////////////////////////////////////////////////////////
    // sense decode

    // true when one sampled pair matches the selected edge or change sense; low sense never hits
    function automatic logic sense_hit(
        input logic [1:0] mode,
        input logic       prev,
        input logic       cur
    );
        logic hit;
        hit = 1'b0;
        case (sense_mode_e'(mode))
            sense_any:  hit = prev ^ cur;
            sense_fall: hit = prev & ~cur;
            sense_rise: hit = ~prev & cur;
            default:    hit = 1'b0;
        endcase
        return hit;
    endfunction : sense_hit

    // per pin mode and edge detection from two successive samples
    always_comb
    begin
        for (int n = 0; n < `NUM_EXT_PINS; n++)
        begin
            level_mode[n]     = (st_ff.sense[2*n +: 2] == 2'b00);
            nxt_level_mode[n] = (nxt_st.sense[2*n +: 2] == 2'b00);
            level_low[n]      = level_mode[n] & ~st_ff.ext_smp[n];
            // no edge is seen while the i/o clock is halted
            ext_hit[n] = io_clock_run &
                sense_hit(st_ff.sense[2*n +: 2],
                          st_ff.ext_prev[n], st_ff.ext_smp[n]);
        end
    end

    // bank change detection, live on every cycle
    always_comb
    begin
        pc_chg      = (st_ff.pc_smp ^ st_ff.pc_prev) & st_ff.pc_mask;
        bank_hit[0] = st_ff.bank_en[0] & (|pc_chg[7:0]);
        bank_hit[1] = st_ff.bank_en[1] & (|pc_chg[15:8]);
        bank_hit[2] = st_ff.bank_en[2] & (|pc_chg[23:16]);
        bank_hit[3] = st_ff.bank_en[3] & (|pc_chg[26:24]);
    end

    ////////////////////////////////////////////////////////////////////////
    // flag clear sources

    // apb write decode and vector entry acknowledge
    always_comb
    begin
        setup_ph = psel & ~penable;
        wr_en    = psel & penable & st_ff.pready & pwrite & ~st_ff.pslverr;
        wr_byte  = pwdata[7:0];
        ext_w1c  = (wr_en && paddr == ADDR_W'(`OFS_EXT_FLAGS))
                   ? wr_byte[3:0] : 4'h0;
        bank_w1c = (wr_en && paddr == ADDR_W'(`OFS_BANK_FLAGS))
                   ? wr_byte[3:0] : 4'h0;
        ext_ack_clr  = 4'h0;
        bank_ack_clr = 4'h0;
        if (irq_ack)
        begin
            if (irq_ack_id[2])
                bank_ack_clr[irq_ack_id[1:0]] = 1'b1;
            else
                ext_ack_clr[irq_ack_id[1:0]] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        nxt_st = st_ff;

        // pins are sampled whatever drives them, own port included
        nxt_st.ext_smp  = ext_irq_pin;
        nxt_st.ext_prev = st_ff.ext_smp;
        nxt_st.pc_smp   = pin_change_input;
        nxt_st.pc_prev  = st_ff.pc_smp;

        // plain register writes
        if (wr_en)
        begin
            case (paddr)
                ADDR_W'(`OFS_SENSE_CONTROL): nxt_st.sense   = wr_byte;
                ADDR_W'(`OFS_EXT_ENABLE):    nxt_st.ext_en  = wr_byte[3:0];
                ADDR_W'(`OFS_BANK_ENABLE):   nxt_st.bank_en = wr_byte[3:0];
                ADDR_W'(`OFS_PC_MASK0):
                    nxt_st.pc_mask[`BANK0_LSB +: 8] = wr_byte;
                ADDR_W'(`OFS_PC_MASK1):
                    nxt_st.pc_mask[`BANK1_LSB +: 8] = wr_byte;
                ADDR_W'(`OFS_PC_MASK2):
                    nxt_st.pc_mask[`BANK2_LSB +: 8] = wr_byte;
                ADDR_W'(`OFS_PC_MASK3):
                    nxt_st.pc_mask[`BANK3_LSB +: `BANK3_WIDTH] =
                        wr_byte[`BANK3_WIDTH-1:0];
                ADDR_W'(`OFS_EVT_MASK):      nxt_st.evt_mask = wr_byte;
                default: ;
            endcase
        end

        // clears first, sets after, so a coincident event survives
        nxt_st.ext_flag = (st_ff.ext_flag & ~ext_w1c & ~ext_ack_clr)
                        | ext_hit;
        nxt_st.ext_flag = nxt_st.ext_flag & ~nxt_level_mode;
        nxt_st.bank_flag = (st_ff.bank_flag & ~bank_w1c & ~bank_ack_clr)
                         | bank_hit;

        // sticky event status for the summary interrupt
        nxt_st.evt_status = st_ff.evt_status;
        if (wr_en && paddr == ADDR_W'(`OFS_EVT_STATUS))
            nxt_st.evt_status = st_ff.evt_status & ~wr_byte;
        nxt_st.evt_status = nxt_st.evt_status
                          | {bank_hit, (ext_hit & ~level_mode) | level_low};

        // requests toward the vectoring logic; level is not latched, so a
        // level gone before wake-up ends leaves no request behind
        for (int n = 0; n < `NUM_EXT_PINS; n++)
        begin
            nxt_st.ext_req[n] = global_irq_enable & st_ff.ext_en[n] &
                (level_mode[n] ? ~st_ff.ext_smp[n]
                               : st_ff.ext_flag[n]);
        end
        nxt_st.bank_req = {4{global_irq_enable}} & st_ff.bank_en
                        & st_ff.bank_flag;
        nxt_st.irq = |(st_ff.evt_status & st_ff.evt_mask);

        // apb answer: data and ready prepared in the setup cycle
        nxt_st.pready  = setup_ph;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata  = 32'h0000_0000;
        if (setup_ph)
        begin
            case (paddr)
                ADDR_W'(`OFS_SENSE_CONTROL):
                    nxt_st.prdata[7:0] = st_ff.sense;
                ADDR_W'(`OFS_EXT_ENABLE):
                    nxt_st.prdata[3:0] = st_ff.ext_en;
                ADDR_W'(`OFS_EXT_FLAGS):
                    nxt_st.prdata[3:0] = st_ff.ext_flag;
                ADDR_W'(`OFS_BANK_ENABLE):
                    nxt_st.prdata[3:0] = st_ff.bank_en;
                ADDR_W'(`OFS_BANK_FLAGS):
                    nxt_st.prdata[3:0] = st_ff.bank_flag;
                ADDR_W'(`OFS_PC_MASK0):
                    nxt_st.prdata[7:0] = st_ff.pc_mask[`BANK0_LSB +: 8];
                ADDR_W'(`OFS_PC_MASK1):
                    nxt_st.prdata[7:0] = st_ff.pc_mask[`BANK1_LSB +: 8];
                ADDR_W'(`OFS_PC_MASK2):
                    nxt_st.prdata[7:0] = st_ff.pc_mask[`BANK2_LSB +: 8];
                ADDR_W'(`OFS_PC_MASK3):
                    nxt_st.prdata[`BANK3_WIDTH-1:0] =
                        st_ff.pc_mask[`BANK3_LSB +: `BANK3_WIDTH];
                ADDR_W'(`OFS_EVT_STATUS):
                    nxt_st.prdata[7:0] = st_ff.evt_status;
                ADDR_W'(`OFS_EVT_MASK):
                    nxt_st.prdata[7:0] = st_ff.evt_mask;
                default:
                    nxt_st.pslverr = 1'b1;    // unmapped, write dropped
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff            <= '0;
            st_ff.sense      <= `RST_SENSE_CONTROL;
            st_ff.ext_en     <= `RST_EXT_ENABLE;
            st_ff.ext_flag   <= `RST_EXT_FLAGS;
            st_ff.bank_en    <= `RST_BANK_ENABLE;
            st_ff.bank_flag  <= `RST_BANK_FLAGS;
            st_ff.pc_mask    <= `RST_PC_MASK;
            st_ff.evt_status <= `RST_EVT;
            st_ff.evt_mask   <= `RST_EVT;
        end
        else
            st_ff <= nxt_st;
    end

    // outputs straight from the state register
    assign prdata                  = st_ff.prdata;
    assign pready                  = st_ff.pready;
    assign pslverr                 = st_ff.pslverr;
    assign ext_irq_req             = st_ff.ext_req;
    assign pin_change_bank_request = st_ff.bank_req;
    assign irq                     = st_ff.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_level_flag_zero: assert property (
        !(|(level_mode & st_ff.ext_flag)))
        else $error("pin flag set while pin is in level mode");

    a_req_needs_gie: assert property (
        (|st_ff.ext_req) |-> $past(global_irq_enable))
        else $error("pin request raised without global enable");

    a_bank_req_gate: assert property (
        (|st_ff.bank_req) |-> $past(global_irq_enable)
            && |($past(st_ff.bank_en) & $past(st_ff.bank_flag)))
        else $error("bank request without enable and flag");

    a_level_holds_req: assert property (
        (global_irq_enable && st_ff.ext_en[0] && level_mode[0]
            && !st_ff.ext_smp[0]) |=> st_ff.ext_req[0])
        else $error("low level did not keep request high");

    a_edge_sets_flag: assert property (
        (ext_hit[0] && !nxt_level_mode[0]) |=> st_ff.ext_flag[0])
        else $error("pin edge did not set flag");

    a_set_beats_clr: assert property (
        (bank_hit[0] && bank_w1c[0]) |=> st_ff.bank_flag[0])
        else $error("bank event lost against clear");

    a_bank_gated_off: assert property (
        (!st_ff.bank_en[1] || !(|st_ff.pc_mask[15:8]))
            |=> !$rose(st_ff.bank_flag[1]))
        else $error("bank flag set while bank gated off");

    a_no_edge_asleep: assert property (
        !io_clock_run |=> !(|(st_ff.ext_flag & ~$past(st_ff.ext_flag))))
        else $error("edge flag set with i/o clock halted");

    a_pc_change_flag: assert property (
        ($changed(pin_change_input[0]) && st_ff.pc_mask[0]
            && st_ff.bank_en[0]) ##1 (st_ff.bank_en[0] && st_ff.pc_mask[0])
            |=> st_ff.bank_flag[0])
        else $error("enabled input change did not set bank flag");

    a_apb_answer: assert property (
        (psel && !penable) |=> st_ff.pready ##1 !st_ff.pready)
        else $error("apb ready not a single cycle after setup");

    // vector entry clears the pin flag unless a new edge lands with it
    a_ack_clears_flag: assert property (
        (|(ext_ack_clr & ~ext_hit))
            |=> !(|(st_ff.ext_flag & $past(ext_ack_clr & ~ext_hit))))
        else $error("pin flag survived vector entry");

    // writing one clears the pin flag
    a_w1c_clears_flag: assert property (
        (|(ext_w1c & ~ext_hit))
            |=> !(|(st_ff.ext_flag & $past(ext_w1c & ~ext_hit))))
        else $error("pin flag survived write one");

    // no sampled edge, no new pin flag
    a_flag_needs_edge: assert property (
        !(|ext_hit) |=> !(|(st_ff.ext_flag & ~$past(st_ff.ext_flag))))
        else $error("pin flag set with no edge");

    // vector entry clears the bank flag
    a_bank_ack_clear: assert property (
        (|(bank_ack_clr & ~bank_hit))
            |=> !(|(st_ff.bank_flag & $past(bank_ack_clr & ~bank_hit))))
        else $error("bank flag survived vector entry");

    // writing one clears the bank flag
    a_bank_w1c_clear: assert property (
        (|(bank_w1c & ~bank_hit))
            |=> !(|(st_ff.bank_flag & $past(bank_w1c & ~bank_hit))))
        else $error("bank flag survived write one");

    // quiet inputs raise no new bank flag
    a_quiet_no_bank: assert property (
        (st_ff.pc_smp == st_ff.pc_prev)
            |=> !(|(st_ff.bank_flag & ~$past(st_ff.bank_flag))))
        else $error("bank flag set with no input change");

    // the short top bank reaches its own flag
    a_bank3_change: assert property (
        ($changed(pin_change_input[24]) && st_ff.pc_mask[24]
            && st_ff.bank_en[3])
            ##1 (st_ff.bank_en[3] && st_ff.pc_mask[24])
            |=> st_ff.bank_flag[3])
        else $error("top bank change did not set its flag");

    // a bank request needs its pending flag
    a_bank_req_flag: assert property (
        (|(~st_ff.bank_flag))
            |=> !(|(st_ff.bank_req & $past(~st_ff.bank_flag))))
        else $error("bank request without its flag");

    // a level-mode pin sampled high drops its request
    a_level_req_drops: assert property (
        (|(level_mode & st_ff.ext_smp))
            |=> !(|(st_ff.ext_req & $past(level_mode & st_ff.ext_smp))))
        else $error("level request outlived the low level");

    // in edge modes a request needs a pending flag
    a_edge_req_flag: assert property (
        (|(~level_mode & ~st_ff.ext_flag))
            |=> !(|(st_ff.ext_req & $past(~level_mode & ~st_ff.ext_flag))))
        else $error("edge request without its flag");

    // summary line follows masked status one cycle later
    a_irq_summary: assert property (
        irq == $past(|(st_ff.evt_status & st_ff.evt_mask)))
        else $error("summary interrupt does not follow status");

    // read data is zero outside the answer cycle
    a_prdata_idle: assert property (
        !st_ff.pready |-> (st_ff.prdata == 32'h0000_0000))
        else $error("read data not zero while idle");

    // error response only comes with ready
    a_slverr_ready: assert property (
        st_ff.pslverr |-> st_ff.pready)
        else $error("error response without ready");

endmodule : external_pin_interrupt_unit

// >>> design/ext_irq_cfg.svh
// register offsets, reset values and field layout of the pin interrupt unit
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

// apb byte offsets
`define OFS_SENSE_CONTROL   8'h00
`define OFS_EXT_ENABLE      8'h04
`define OFS_EXT_FLAGS       8'h08
`define OFS_BANK_ENABLE     8'h0c
`define OFS_BANK_FLAGS      8'h10
`define OFS_PC_MASK0        8'h14
`define OFS_PC_MASK1        8'h18
`define OFS_PC_MASK2        8'h1c
`define OFS_PC_MASK3        8'h20
`define OFS_EVT_STATUS      8'h24
`define OFS_EVT_MASK        8'h28

// reset values
`define RST_SENSE_CONTROL   8'h00
`define RST_EXT_ENABLE      4'h0
`define RST_EXT_FLAGS       4'h0
`define RST_BANK_ENABLE     4'h0
`define RST_BANK_FLAGS      4'h0
`define RST_PC_MASK         27'h0000000
`define RST_EVT             8'h00

// field layout
`define NUM_EXT_PINS        4
`define NUM_BANKS           4
`define NUM_PC_INPUTS       27
`define SENSE_FIELD_W       2
`define BANK0_LSB           0
`define BANK1_LSB           8
`define BANK2_LSB           16
`define BANK3_LSB           24
`define BANK3_WIDTH         3
`define EVT_BANK_LSB        4
`define ACK_BANK_BASE       3'h4

`endif

// >>> design/ext_irq_pkg.sv
// types shared by the pin interrupt unit
package ext_irq_pkg;
    `include "ext_irq_cfg.svh"

    // sense selection per dedicated pin, in field code order 00..11
    typedef enum logic [1:0] {
        sense_low,
        sense_any,
        sense_fall,
        sense_rise
    } sense_mode_e;

    // complete state of the unit
    typedef struct packed {
        logic [7:0]                  sense;
        logic [`NUM_EXT_PINS-1:0]    ext_en;
        logic [`NUM_EXT_PINS-1:0]    ext_flag;
        logic [`NUM_BANKS-1:0]       bank_en;
        logic [`NUM_BANKS-1:0]       bank_flag;
        logic [`NUM_PC_INPUTS-1:0]   pc_mask;
        logic [7:0]                  evt_status;
        logic [7:0]                  evt_mask;
        logic [`NUM_EXT_PINS-1:0]    ext_smp;
        logic [`NUM_EXT_PINS-1:0]    ext_prev;
        logic [`NUM_PC_INPUTS-1:0]   pc_smp;
        logic [`NUM_PC_INPUTS-1:0]   pc_prev;
        logic [`NUM_EXT_PINS-1:0]    ext_req;
        logic [`NUM_BANKS-1:0]       bank_req;
        logic                        irq;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
    } unit_state_s;
endpackage : ext_irq_pkg

// >>> bench/vector_model.sv
// processor vectoring model: enters one pending vector at a time
module vector_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ack_on,
    input  wire logic [3:0] ext_irq_req,
    input  wire logic [3:0] pin_change_bank_request,
    output logic            irq_ack,
    output logic [2:0]      irq_ack_id
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pend;
    int         gap;
    logic [2:0] id;
    assign pend = {pin_change_bank_request, ext_irq_req};
    // pause after each entry so the served request has time to fall
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ack    <= 1'b0;
            irq_ack_id <= 3'h0;
            gap = 0;
        end
        else if (irq_ack || gap > 0)
        begin
            irq_ack <= 1'b0;
            gap = (gap + 1) % 4;
        end
        else if (ack_on && pend != 8'h00)
        begin
            // lowest pending vector wins, one assignment per edge
            for (int i = 7; i >= 0; i--)
                if (pend[i]) id = 3'(i);
            irq_ack    <= 1'b1;
            irq_ack_id <= id;
        end
    end
endmodule : vector_model

// >>> bench/external_pin_interrupt_unit_test.sv
// self-checking bench of the pin interrupt unit
`include "ext_irq_cfg.svh"
module external_pin_interrupt_unit_test;
    import ext_irq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, wv, seed;
    logic [3:0]  ext_irq_pin, ext_irq_req, pin_change_bank_request;
    logic [26:0] pin_change_input;
    logic        global_irq_enable, io_clock_run, irq_ack, irq, ack_on, st;
    logic [2:0]  irq_ack_id;
    logic        err;
    int          num_errors, n_compared, i, j, b;
    logic [7:0]  ofs [8] = '{8'h00, 8'h04, 8'h0c, 8'h14,
                             8'h18, 8'h1c, 8'h20, 8'h28};
    logic [7:0]  wmask [8] = '{8'hff, 8'h0f, 8'h0f, 8'hff,
                               8'hff, 8'hff, 8'h07, 8'hff};

    external_pin_interrupt_unit external_pin_interrupt_unit_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
        .pin_change_input(pin_change_input),
        .global_irq_enable(global_irq_enable), .io_clock_run(io_clock_run),
        .irq_ack(irq_ack), .irq_ack_id(irq_ack_id),
        .ext_irq_req(ext_irq_req),
        .pin_change_bank_request(pin_change_bank_request), .irq(irq));
    vector_model vector_model_i (
        .pclk(pclk), .presetn(presetn), .ack_on(ack_on),
        .ext_irq_req(ext_irq_req),
        .pin_change_bank_request(pin_change_bank_request),
        .irq_ack(irq_ack), .irq_ack_id(irq_ack_id));

    ////////////////////////////////////////////////////////////////////
    // clock, 20 ns period
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    function automatic logic [31:0] xrand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xrand

    // does a sample pair hit the sense mode
    function automatic logic edge_hit(int m, logic a, logic c);
        return (m == 1) ? (a != c) : (m == 2) ? (a & !c) : (m == 3) && !a && c;
    endfunction : edge_hit

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one apb transfer; waits for pready with no fixed latency assumed
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no fixed latency: only the watchdog ends a wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(logic [7:0] a, logic [31:0] exp, string what);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
        check({what, " error"}, 32'h0, {31'h0, err});
    endtask : rdchk

    task automatic tick(int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the roughly 1100 cycles the tests need
    initial
    begin
        tick(40000);
        num_errors++;
        $display("watchdog expired");
        final_report();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        {ext_irq_pin, pin_change_input, ack_on} <= '0;
        {global_irq_enable, io_clock_run} <= '0;
        presetn <= 1'b0;
        seed = 32'h1d37;
        tick(6);
        presetn <= 1'b1;
        // reset values and an unmapped word
        // pins start low in level mode, so status shows level events
        for (int a = 0; a <= 'h28; a += 4)
            rdchk(8'(a), (a == 'h24) ? 32'hf : 32'h0, "reset value");
        apb(1'b0, 8'h2c, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        // random readback, upper bits read zero
        for (int k = 0; k < 8; k++)
        begin
            wv = xrand();
            wr(ofs[k], wv);
            rdchk(ofs[k], {24'h0, wv[7:0] & wmask[k]}, "readback");
            wr(ofs[k], 32'h0);
        end
        $display("test registers done");
        ////////////////////////////////////////////////////////////////
        // edge modes on every pin, opposite edge after
        global_irq_enable <= 1'b1;
        io_clock_run      <= 1'b1;
        for (int m = 1; m < 4; m++)
            for (int p = 0; p < 4; p++)
            begin
                st = xrand() & 1;
                wr(`OFS_EXT_ENABLE, 32'h0);
                wr(`OFS_SENSE_CONTROL, m << (2 * p));
                wr(`OFS_EVT_MASK, 1 << p);
                ext_irq_pin[p] <= st;
                tick(4);
                wr(`OFS_EXT_FLAGS, 32'hf);
                wr(`OFS_EVT_STATUS, 32'hff);
                wr(`OFS_EXT_ENABLE, 1 << p);
                ext_irq_pin[p] <= !st;
                tick(5);
                check("pin req", edge_hit(m, st, !st) << p, ext_irq_req);
                check("irq line", edge_hit(m, st, !st), irq);
                rdchk(`OFS_EXT_FLAGS, edge_hit(m, st, !st) << p, "flag");
                wr(`OFS_EXT_FLAGS, 1 << p);
                ext_irq_pin[p] <= st;
                tick(5);
                rdchk(`OFS_EXT_FLAGS, edge_hit(m, !st, st) << p, "flag back");
            end
        // stopped io clock, then global disable, then vector entry
        wr(`OFS_EXT_ENABLE, 32'h0);
        wr(`OFS_SENSE_CONTROL, 32'hff);
        wr(`OFS_EXT_ENABLE, 32'hf);
        ext_irq_pin <= 4'h0;
        tick(4);
        wr(`OFS_EXT_FLAGS, 32'hf);
        io_clock_run <= 1'b0;
        ext_irq_pin  <= 4'hf;
        tick(5);
        rdchk(`OFS_EXT_FLAGS, 32'h0, "no clock flag");
        io_clock_run      <= 1'b1;
        global_irq_enable <= 1'b0;
        ext_irq_pin       <= 4'h0;
        tick(5);
        rdchk(`OFS_EXT_FLAGS, 32'h0, "falling ignored");
        ext_irq_pin <= 4'hf;
        tick(5);
        rdchk(`OFS_EXT_FLAGS, 32'hf, "gie off flag");
        check("gie off req", 4'h0, ext_irq_req);
        global_irq_enable <= 1'b1;
        ack_on            <= 1'b1;
        tick(40);
        rdchk(`OFS_EXT_FLAGS, 32'h0, "acked flags");
        check("acked req", 4'h0, ext_irq_req);
        ack_on <= 1'b0;
        $display("test edges done");
        ////////////////////////////////////////////////////////////////
        // level mode with the io clock stopped
        wr(`OFS_EXT_ENABLE, 32'h0);
        wr(`OFS_SENSE_CONTROL, 32'h0);
        wr(`OFS_EXT_ENABLE, 32'hf);
        io_clock_run <= 1'b0;
        ext_irq_pin  <= 4'h0;
        tick(4);
        check("level req", 4'hf, ext_irq_req);
        tick(6);
        check("level held", 4'hf, ext_irq_req);
        rdchk(`OFS_EXT_FLAGS, 32'h0, "level flag");
        ext_irq_pin <= 4'h5;
        tick(4);
        check("level release", 4'ha, ext_irq_req);
        $display("test level done");
        ////////////////////////////////////////////////////////////////
        // pin-change banks, io clock still stopped
        pin_change_input <= 27'(xrand());
        wr(`OFS_BANK_ENABLE, 32'hf);
        for (int k = 0; k < 10; k++)
        begin
            i = xrand() % 27;
            b = i / 8;
            for (int bb = 0; bb < 4; bb++)
                wr(8'(`OFS_PC_MASK0 + 4 * bb), (bb == b) << (i - 8 * b));
            wr(`OFS_BANK_FLAGS, 32'hf);
            pin_change_input[i] <= !pin_change_input[i];
            tick(5);
            rdchk(`OFS_BANK_FLAGS, 1 << b, "bank flag");
            check("bank req", 1 << b, pin_change_bank_request);
            wr(`OFS_BANK_FLAGS, 32'hf);
            j = (i + 1 + xrand() % 26) % 27;
            pin_change_input[j] <= !pin_change_input[j];
            tick(5);
            rdchk(`OFS_BANK_FLAGS, 32'h0, "masked input");
        end
        // vector entry on the last bank, with no pin left pending
        wr(`OFS_EXT_ENABLE, 32'h0);
        tick(2);
        pin_change_input[i] <= !pin_change_input[i];
        ack_on <= 1'b1;
        tick(4);
        check("bank req up", 1 << b, pin_change_bank_request);
        tick(8);
        rdchk(`OFS_BANK_FLAGS, 32'h0, "bank acked");
        check("bank acked req", 4'h0, pin_change_bank_request);
        ack_on <= 1'b0;
        wr(`OFS_BANK_ENABLE, 32'h0);
        pin_change_input[i] <= !pin_change_input[i];
        tick(5);
        rdchk(`OFS_BANK_FLAGS, 32'h0, "bank disabled");
        $display("test banks done");
        final_report();
    end
endmodule : external_pin_interrupt_unit_test
